// *** verilog/pucf_pkg.sv ***
// Purpose: Shared constants and types of the power-up strap configuration.
// Assumes: One 10 MHz clock; registers on a plain 4-bit address port.
// Notes:   Every offset, the control, config and status field positions and the time live here, and the access-enable and read-idle reset values.
package pucf_pkg;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_BASIC,
        MODE_EXT,
        MODE_ADDIN,
        MODE_MBOARD
    } pucf_mode_t;

    typedef enum logic [1:0] {
        PP_ISA,
        PP_PS2,
        PP_EPP,
        PP_ECP
    } pucf_pp_t;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_CONFIG = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_STRAPS = 4'h3;

    localparam int CTRL_ACCESS_EN = 0;
    localparam int CTRL_TO_ADDIN  = 1;
    localparam int CFG_PP_LSB     = 0;
    localparam int CFG_FOUR       = 2;
    localparam int CFG_V3         = 3;
    localparam int CFG_GAME       = 4;
    localparam int STAT_MODE_LSB  = 0;
    localparam int STAT_FINAL     = 2;
    localparam int STAT_WAITING   = 3;
    localparam int STAT_ALT_ADDR  = 4;

    localparam logic       RST_ACCESS_EN = 1'b1;
    localparam logic [7:0] RDATA_IDLE    = 8'h00;

    // ------------------------------------------------------------
    // Configuration register pair bases
    // ------------------------------------------------------------
    localparam logic [9:0] CFG_BASE_PRIMARY = 10'h398;
    localparam logic [9:0] CFG_BASE_ALT     = 10'h26E;
    localparam logic [9:0] CFG_BASE_MB_LOW  = 10'h022;
    localparam logic [9:0] CFG_BASE_MB_HIGH = 10'h024;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 10;
    localparam int SECOND_SAMPLE_NS = 1000;

    // A least time: round up, never below one cycle.
    function automatic int pucf_cycles(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

endpackage

// *** verilog/pucf_dec_if.sv ***
// Purpose: Carries latched mode and decode hits between top and decoder.
// Assumes: Same clock domain on both ends.
// Notes:   Hits are combinational from synchronised address lines.
`timescale 1ns/1ps
interface pucf_dec_if;
    import pucf_pkg::*;
    pucf_mode_t mode;
    logic       addr_alt;
    logic       access_en;
    logic       index_hit;
    logic       data_hit;

    modport ctl (output mode, output addr_alt, output access_en,
                 input index_hit, input data_hit);
    modport dec (input mode, input addr_alt, input access_en,
                 output index_hit, output data_hit);
endinterface

// *** verilog/pucf_cfg_decode.sv ***
// Purpose: Decodes the configuration index/data pair from the I/O address.
// Assumes: Address and enable already synchronised to ref_clk.
// Notes:   All ten address lines take part in the match.
`timescale 1ns/1ps
module pucf_cfg_decode
    import pucf_pkg::*;
(
    input  wire logic [9:0] isa_addr,
    input  wire logic       isa_aen,
    pucf_dec_if.dec         bus
);

    // ------------------------------------------------------------
    // Pair match
    // ------------------------------------------------------------
    function automatic logic pucf_at(input logic [9:0] a,
                                     input logic [9:0] base,
                                     input logic       odd);
        return a == (base | {9'h000, odd});
    endfunction

    logic [9:0] base;
    logic [9:0] addin_base;
    logic [9:0] mb_base;
    logic       enabled;

    assign addin_base = bus.addr_alt ? CFG_BASE_ALT : CFG_BASE_PRIMARY;
    assign mb_base    = bus.addr_alt ? CFG_BASE_MB_HIGH : CFG_BASE_MB_LOW;

    // Basic and extended modes share the fixed pair, and only when enabled.
    assign base = (bus.mode == MODE_ADDIN)  ? addin_base :
                  (bus.mode == MODE_MBOARD) ? mb_base :
                  CFG_BASE_PRIMARY;

    assign enabled = !isa_aen &&
                     ((bus.mode == MODE_ADDIN) ||
                      (bus.mode == MODE_MBOARD) ||
                      bus.access_en);

    assign bus.index_hit = enabled && pucf_at(isa_addr, base, 1'b0);
    assign bus.data_hit  = enabled && pucf_at(isa_addr, base, 1'b1);

endmodule

// *** verilog/pucf_strap_config.sv ***
// Purpose: Latches power-up straps from the serial pins at reset-drive.
// Assumes: Reset-drive, straps and ISA address arrive from pins.
// Notes:   Pins pass two flip-flops; the multi-bit address is only
//          meaningful while the bus holds it stable for several cycles.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

// Function
// - Capture all straps when reset-drive goes from high to low.
// - Basic and both software modes finish configuration on that capture.
// - Extended mode takes its first strap bank at the reset-drive fall.
// - Extended mode samples all six serial pins again after fixed delay.
// - Basic, extended and add-in modes make dual pin the game select.
// - Basic mode forces ISA parallel mode and 5V supply.
// - Basic mode fixes the floppy controller at two drives.
// - Basic mode decodes config pair only at 398h/399h when enabled.
// - Extended mode strap selects two or four floppy drives.
// - Extended mode straps select ISA, PS/2 or EPP parallel mode.
// - Extended mode strap selects 3.3V or 5V operation.
// - Add-in mode decodes config pair at 398h/399h or 26Eh/26Fh.
// - Software modes take the supply level from a strap.
// - Motherboard mode decodes config pair at 22h/23h or 24h/25h.
// - Motherboard mode makes dual pin the parallel direction output.
// - All ten address lines are decoded for the config pair.
// - Mode straps 00 ISA, 01 PS/2, 10 EPP, 11 reserved.
// - ECP parallel mode is never reached from straps.
// - Floppy strap 0 gives two drives, 1 gives four, extended only.
module pucf_strap_config
    import pucf_pkg::*;
#(
    parameter int SECOND_CYCLES = pucf_cycles(SECOND_SAMPLE_NS)
)
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       reset_drive_pin,
    input  wire logic [1:0] cfg_mode_pins,
    input  wire logic       serial_a_tx_pin,
    input  wire logic       serial_b_tx_pin,
    input  wire logic       serial_a_rts_pin,
    input  wire logic       serial_b_rts_pin,
    input  wire logic       serial_a_dtr_pin,
    input  wire logic       serial_b_dtr_pin,
    input  wire logic [9:0] isa_addr,
    input  wire logic       isa_aen,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic      [1:0] cfg_mode,
    output logic      [1:0] pp_mode,
    output logic            four_floppy,
    output logic            supply_3v3,
    output logic            game_cs_function,
    output logic      [3:0] serial_cfg,
    output logic      [1:0] parallel_cfg,
    output logic            cfg_index_hit,
    output logic            cfg_data_hit,
    output logic            config_final
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HELD,
        ST_WAIT_SECOND,
        ST_FINAL
    } pucf_state_t;

    logic [7:0]  pins_s1;
    logic [7:0]  pins_s2;
    logic [10:0] addr_s1;
    logic [10:0] addr_s2;
    logic        drive_s1;
    logic        drive_s2;
    logic        drive_s3;

    always_ff @(posedge ref_clk)
    begin
        pins_s1  <= {cfg_mode_pins, serial_b_dtr_pin, serial_a_dtr_pin,
                     serial_b_rts_pin, serial_a_rts_pin,
                     serial_b_tx_pin, serial_a_tx_pin};
        pins_s2  <= pins_s1;
        addr_s1  <= {isa_aen, isa_addr};
        addr_s2  <= addr_s1;
        drive_s1 <= reset_drive_pin;
        drive_s2 <= drive_s1;
        drive_s3 <= drive_s2;
    end

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    logic       tx_a;
    logic       tx_b;
    logic       rts_a;
    logic       rts_b;
    logic       dtr_a;
    logic       dtr_b;
    pucf_mode_t pin_mode;
    logic       drive_fall;
    logic       drive_rise;
    pucf_pp_t   strap_pp;

    assign tx_a       = pins_s2[0];
    assign tx_b       = pins_s2[1];
    assign rts_a      = pins_s2[2];
    assign rts_b      = pins_s2[3];
    assign dtr_a      = pins_s2[4];
    assign dtr_b      = pins_s2[5];
    assign pin_mode   = pucf_mode_t'(pins_s2[7:6]);
    assign drive_fall = drive_s3 && !drive_s2;
    assign drive_rise = !drive_s3 && drive_s2;

    // The reserved code falls back to ISA, so straps never yield ECP.
    assign strap_pp = ({rts_a, tx_b} == 2'b01) ? PP_PS2 :
                      ({rts_a, tx_b} == 2'b10) ? PP_EPP :
                      PP_ISA;

    logic is_basic;
    logic is_ext;
    logic is_mb;
    assign is_basic = (pin_mode == MODE_BASIC);
    assign is_ext   = (pin_mode == MODE_EXT);
    assign is_mb    = (pin_mode == MODE_MBOARD);

    logic [1:0] cap_pp;
    logic       cap_four;
    logic       cap_v3;
    logic       cap_game;
    logic       cap_alt;
    assign cap_pp   = is_ext ? strap_pp : PP_ISA;
    assign cap_four = is_ext && rts_b;
    assign cap_v3   = !is_basic && dtr_b;
    assign cap_game = !is_mb;
    assign cap_alt  = !is_basic && dtr_a;

    // ------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------
    logic ctrl_wr;
    logic config_wr;
    logic sw_mode;

    assign sw_mode   = (cfg_mode == MODE_ADDIN) ||
                       (cfg_mode == MODE_MBOARD);
    assign ctrl_wr   = reg_wr && (reg_addr == REG_CTRL);
    // Settings only move by software once a software mode is in force.
    assign config_wr = reg_wr && (reg_addr == REG_CONFIG) && sw_mode;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    pucf_state_t state;
    pucf_state_t next_state;
    logic [15:0] wait_cnt;
    logic        second_due;
    logic        take_first;
    logic        take_second;

    assign second_due  = (state == ST_WAIT_SECOND) &&
                         (wait_cnt == 16'(SECOND_CYCLES - 1));
    assign take_first  = drive_fall &&
                         ((state == ST_HELD) || (state == ST_IDLE));
    assign take_second = second_due && !drive_rise;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE, ST_HELD:
                if (drive_fall)
                    next_state = is_ext ? ST_WAIT_SECOND : ST_FINAL;
                else if (drive_s2)
                    next_state = ST_HELD;
            ST_WAIT_SECOND:
                if (drive_rise)
                    next_state = ST_HELD;
                else if (second_due)
                    next_state = ST_FINAL;
            ST_FINAL:
                if (drive_rise)
                    next_state = ST_HELD;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst || state != ST_WAIT_SECOND)
            wait_cnt <= 16'h0000;
        else
            wait_cnt <= wait_cnt + 16'h0001;
    end

    // ------------------------------------------------------------
    // Latched configuration
    // ------------------------------------------------------------
    logic access_en;
    logic addr_alt;
    // The first bank in extended mode is held by the external buffer and
    // the second bank comes from resistors once that buffer floats.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cfg_mode         <= MODE_BASIC;
            pp_mode          <= PP_ISA;
            four_floppy      <= 1'b0;
            supply_3v3       <= 1'b0;
            game_cs_function <= 1'b1;
            addr_alt         <= 1'b0;
        end
        else if (take_first)
        begin
            cfg_mode         <= pin_mode;
            pp_mode          <= cap_pp;
            four_floppy      <= cap_four;
            supply_3v3       <= cap_v3;
            game_cs_function <= cap_game;
            addr_alt         <= cap_alt;
        end
        else if (ctrl_wr && reg_wdata[CTRL_TO_ADDIN])
            cfg_mode <= MODE_ADDIN;
        else if (config_wr)
        begin
            pp_mode          <= reg_wdata[CFG_PP_LSB +: 2];
            four_floppy      <= reg_wdata[CFG_FOUR];
            supply_3v3       <= reg_wdata[CFG_V3];
            game_cs_function <= reg_wdata[CFG_GAME];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            serial_cfg   <= 4'h0;
            parallel_cfg <= 2'b00;
        end
        else if ((take_first && !is_ext) || take_second)
        begin
            serial_cfg   <= {rts_b, rts_a, tx_b, tx_a};
            parallel_cfg <= {dtr_b, dtr_a};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            access_en <= RST_ACCESS_EN;
        else if (ctrl_wr)
            access_en <= reg_wdata[CTRL_ACCESS_EN];
    end

    assign config_final = (state == ST_FINAL);

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    logic [7:0] read_mux;

    assign read_mux =
        (reg_addr == REG_CTRL)   ? {7'h00, access_en} :
        (reg_addr == REG_CONFIG) ? {3'b000, game_cs_function, supply_3v3,
                                    four_floppy, pp_mode} :
        (reg_addr == REG_STATUS) ? {3'b000, addr_alt,
                                    state == ST_WAIT_SECOND,
                                    config_final, cfg_mode} :
        (reg_addr == REG_STRAPS) ? {2'b00, parallel_cfg, serial_cfg} :
        RDATA_IDLE;

    always_ff @(posedge ref_clk)
    begin
        if (rst || !reg_rd)
            reg_rdata <= RDATA_IDLE;
        else
            reg_rdata <= read_mux;
    end

    // ------------------------------------------------------------
    // Configuration address decode
    // ------------------------------------------------------------
    pucf_dec_if dec_bus ();

    assign dec_bus.mode      = pucf_mode_t'(cfg_mode);
    assign dec_bus.addr_alt  = addr_alt;
    assign dec_bus.access_en = access_en;
    assign cfg_index_hit     = dec_bus.index_hit;
    assign cfg_data_hit      = dec_bus.data_hit;

    pucf_cfg_decode u_decode (
        .isa_addr (addr_s2[9:0]),
        .isa_aen  (addr_s2[10]),
        .bus      (dec_bus)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic [15:0] wait_seen;

    always_ff @(posedge ref_clk)
    begin
        if (rst || take_first)
            wait_seen <= 16'h0000;
        else
            wait_seen <= wait_seen + 16'h0001;
    end
    sequence s_ext_fall;
        take_first && is_ext;
    endsequence
    sequence s_plain_fall;
        take_first && !is_ext;
    endsequence
    a_single_capture: assert property (
        s_plain_fall |=> config_final && serial_cfg == $past({rts_b,
            rts_a, tx_b, tx_a}))
        else $error("plain mode did not finish on first capture");
    a_ext_first_bank: assert property (
        s_ext_fall |=> state == ST_WAIT_SECOND &&
            four_floppy == $past(rts_b) && supply_3v3 == $past(dtr_b))
        else $error("extended first bank not taken");
    a_second_delay: assert property (
        $rose(config_final) && $past(state) == ST_WAIT_SECOND |->
            $past(wait_seen) == 16'(SECOND_CYCLES - 1))
        else $error("second bank sampled at wrong time");
    a_second_bank: assert property (
        take_second |=> serial_cfg == $past({rts_b, rts_a, tx_b, tx_a})
            && parallel_cfg == $past({dtr_b, dtr_a}))
        else $error("second bank not latched");
    a_game_default: assert property (
        s_plain_fall ##1 (cfg_mode != MODE_MBOARD) |-> game_cs_function)
        else $error("dual pin not game select");
    a_mb_direction: assert property (
        take_first && is_mb |=> !game_cs_function)
        else $error("dual pin not direction output");
    a_basic_forced: assert property (
        take_first && is_basic |=> pp_mode == PP_ISA && !supply_3v3
            && !four_floppy)
        else $error("basic mode settings not forced");
    a_ext_pp_mode: assert property (
        s_ext_fall |=> pp_mode == $past(strap_pp) && pp_mode != PP_ECP)
        else $error("extended parallel mode wrong");
    a_basic_addr: assert property (
        cfg_index_hit && cfg_mode == MODE_BASIC |->
            addr_s2[9:0] == CFG_BASE_PRIMARY && access_en)
        else $error("basic config decode off fixed pair");
    a_addin_addr: assert property (
        cfg_data_hit && cfg_mode == MODE_ADDIN |-> addr_s2[9:0] ==
            ((addr_alt ? CFG_BASE_ALT : CFG_BASE_PRIMARY) | 10'h001))
        else $error("add-in config decode wrong");
    a_mb_addr: assert property (
        cfg_index_hit && cfg_mode == MODE_MBOARD |-> addr_s2[9:0] ==
            (addr_alt ? CFG_BASE_MB_HIGH : CFG_BASE_MB_LOW))
        else $error("motherboard config decode wrong");
    a_hold_latched: assert property (
        config_final && !drive_rise && !ctrl_wr && !config_wr |=>
            $stable(pp_mode) && $stable(four_floppy) && $stable(cfg_mode))
        else $error("latched straps changed without cause");

endmodule

// *** tb/pucf_strap_partner.sv ***
// Purpose: Strap resistors and tri-state bank buffer on the serial pins.
// Assumes: Bit order tx_a, tx_b, rts_a, rts_b, dtr_a, dtr_b.
// Notes:   The buffer lets go one cycle after reset-drive falls.
`timescale 1ns/1ps
module pucf_strap_partner
(
    input  wire logic       ref_clk,
    input  wire logic       reset_drive,
    input  wire logic       fitted,
    input  wire logic [5:0] bank_one,
    input  wire logic [5:0] bank_two,
    output logic      [5:0] pins
);
    logic buf_on = 1'b0;

    // A real buffer has propagation delay, so its release lags the fall.
    always @(posedge ref_clk)
        buf_on <= reset_drive & fitted;

    // Released pins settle to the resistor bank, not to the old level.
    assign pins = buf_on ? bank_one : bank_two;
endmodule

// *** tb/pucf_strap_config_tb.sv ***
// Purpose: Self-checking bench for the power-up strap configuration.
// Assumes: Register port and pin timing as handed over by the designer.
// Notes:   A short second-sample delay keeps each power-up brief.
`timescale 1ns/1ps
module pucf_strap_config_tb;
    import pucf_pkg::*;
    localparam int SC = 4;
    logic       ref_clk     = 1'b0;
    logic       rst         = 1'b1;
    logic       reset_drive = 1'b1;
    logic [1:0] mode_pins   = 2'b00;
    logic       fitted      = 1'b0;
    logic [5:0] bank_one    = 6'h00;
    logic [5:0] bank_two    = 6'h00;
    logic [9:0] isa_addr    = 10'h000;
    logic       isa_aen     = 1'b1;
    logic [3:0] reg_addr    = 4'h0;
    logic [7:0] reg_wdata   = 8'h00;
    logic       reg_wr      = 1'b0;
    logic       reg_rd      = 1'b0;
    logic [5:0] pins;
    logic [7:0] reg_rdata;
    logic [1:0] cfg_mode, pp_mode, parallel_cfg;
    logic [3:0] serial_cfg;
    logic       four_floppy, supply_3v3, game_cs_function;
    logic       cfg_index_hit, cfg_data_hit, config_final;
    logic [1:0] last_mode   = 2'b00;
    int         failures    = 0;
    int         n_compared  = 0;
    int         cycles      = 0;

    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    pucf_strap_partner pucf_strap_partner_inst (.ref_clk(ref_clk),
        .reset_drive(reset_drive), .fitted(fitted), .bank_one(bank_one),
        .bank_two(bank_two), .pins(pins));

    pucf_strap_config #(.SECOND_CYCLES(SC)) pucf_strap_config_inst (
        .ref_clk(ref_clk), .rst(rst), .reset_drive_pin(reset_drive),
        .cfg_mode_pins(mode_pins), .serial_a_tx_pin(pins[0]),
        .serial_b_tx_pin(pins[1]), .serial_a_rts_pin(pins[2]),
        .serial_b_rts_pin(pins[3]), .serial_a_dtr_pin(pins[4]),
        .serial_b_dtr_pin(pins[5]), .isa_addr(isa_addr),
        .isa_aen(isa_aen), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cfg_mode(cfg_mode), .pp_mode(pp_mode),
        .four_floppy(four_floppy), .supply_3v3(supply_3v3),
        .game_cs_function(game_cs_function), .serial_cfg(serial_cfg),
        .parallel_cfg(parallel_cfg), .cfg_index_hit(cfg_index_hit),
        .cfg_data_hit(cfg_data_hit), .config_final(config_final));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [9:0] exp,
                       input logic [9:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Pair base, data address, one far address bit flipped, then AEN high.
    task automatic dec(input logic [9:0] base, input logic hit);
        logic [9:0] a [4];
        a = '{base, base + 10'h001, base ^ 10'h200, base};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk);
            isa_addr <= a[i];
            isa_aen  <= (i == 3);
            repeat (4) @(posedge ref_clk);
            #1;
            chk("index_hit", hit && i == 0, cfg_index_hit);
            chk("data_hit", hit && i == 1, cfg_data_hit);
        end
    endtask

    task automatic run(input logic [1:0] m, input logic [5:0] b1,
                       input logic [5:0] b2);
        int         n;
        logic [7:0] d;
        logic       alt;
        logic [9:0] base;
        logic [1:0] pp;
        if (m != 2'd1)
            b2 = b1;
        alt  = (m != 2'd0) && b1[4];
        base = (m == 2'd3) ? (alt ? CFG_BASE_MB_HIGH : CFG_BASE_MB_LOW)
             : (m == 2'd2 && alt) ? CFG_BASE_ALT : CFG_BASE_PRIMARY;
        pp   = (m == 2'd1 && b1[2:1] != 2'b11) ? b1[2:1] : 2'b00;
        @(posedge ref_clk);
        mode_pins   <= m;
        bank_one    <= b1;
        bank_two    <= b2;
        fitted      <= (m == 2'd1);
        reset_drive <= 1'b1;
        repeat (6) @(posedge ref_clk);
        reset_drive <= 1'b0;
        n = 0;
        while (cfg_mode !== m && n < 20)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (m != last_mode)
            chk("final_at_capture", m != 2'd1, config_final);
        n = 0;
        while (config_final !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (m == 2'd1 && m != last_mode)
            chk("second_delay", 10'(SC), 10'(n));
        chk("config_final", 1'b1, config_final);
        @(posedge ref_clk);
        bank_one <= ~b1;
        bank_two <= ~b2;
        repeat (4) @(posedge ref_clk);
        #1;
        chk("cfg_mode", m, cfg_mode);
        chk("pp_mode", pp, pp_mode);
        chk("four", m == 2'd1 && b1[3], four_floppy);
        chk("v3", m != 2'd0 && b1[5], supply_3v3);
        chk("game_cs", m != 2'd3, game_cs_function);
        if (m < 2'd2)
            chk("straps", b2, {parallel_cfg, serial_cfg});
        rd(REG_STATUS, d);
        chk("status", {alt, 1'b0, 1'b1, m}, d[4:0]);
        dec(base, 1'b1);
        if (m < 2'd2)
            dec(CFG_BASE_ALT, 1'b0);
        last_mode = m;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            results();
        end
    end

    initial
    begin
        logic [7:0] d;
        logic [5:0] b1, b2;
        logic [1:0] modes [10];
        int         seed;
        seed  = $urandom(72);
        modes = '{2'd0, 2'd1, 2'd2, 2'd1, 2'd3, 2'd0, 2'd1, 2'd3,
                  2'd2, 2'd0};
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        rd(REG_CTRL, d);
        chk("ctrl_reset", 8'h01, d);
        rd(REG_STATUS, d);
        chk("status_reset", 8'h00, d);
        for (int i = 0; i < 10; i++)
        begin
            b1 = 6'($urandom);
            b2 = 6'($urandom);
            if (i == 1)
                b1[2:1] = 2'b11;
            else if (i == 3)
                b1[2:1] = 2'b01;
            else if (i == 6)
                b1[2:1] = 2'b10;
            run(modes[i], b1, b2);
        end
        // Hardware modes refuse a direct rewrite of the latched setup.
        wr(REG_CONFIG, 8'h1F);
        rd(REG_CONFIG, d);
        chk("config_refused", 8'h10, d);
        wr(REG_CTRL, 8'h00);
        dec(CFG_BASE_PRIMARY, 1'b0);
        wr(REG_CTRL, 8'h03);
        @(posedge ref_clk);
        #1;
        chk("to_addin", 2'd2, cfg_mode);
        dec(CFG_BASE_PRIMARY, 1'b1);
        wr(REG_CONFIG, 8'h0F);
        rd(REG_CONFIG, d);
        chk("config_sw", 8'h0F, d);
        chk("pp_ecp", 2'd3, pp_mode);
        chk("game_off", 1'b0, game_cs_function);
        rd(4'hF, d);
        chk("unmapped", 8'h00, d);
        rd(REG_CTRL, d);
        chk("ctrl", 8'h01, d);
        results();
    end
endmodule
